// *** src/bier_pkg.sv ***
// constants and carrier types of the bias, identification and error register slice
// assumes a plain register port with read data one cycle after the read strobe
// How it works
// - sixteen-bit bias enable register, resets zero
// - bit n drives bias on input n
// - read-only identification byte ignores writes
// - reserved nibble, revision bits, model bits
// - twelve-bit error flags, resets zero
// - flag sets only when enabled
// - flags readable, cleared by writing one
// - bit eleven flags positive input fault
package bier_pkg;
  localparam logic [7:0]  ADDR_BIAS_EN   = 8'h04;
  localparam logic [7:0]  ADDR_ID        = 8'h05;
  localparam logic [7:0]  ADDR_ERR       = 8'h06;
  localparam logic [7:0]  ADDR_ERR_EN    = 8'h07;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h09;
  localparam logic [15:0] BIAS_EN_RESET  = 16'h0000;
  localparam logic [15:0] ERR_RESET      = 16'h0000;
  localparam logic [15:0] ERR_EN_RESET   = 16'h0000;
  localparam logic [15:0] ERR_IMPL_MASK  = 16'h0fff;
  localparam int          POS_FAULT_BIT  = 11;
  localparam logic [3:0]  ID_RSVD        = 4'h0;
  localparam int          IRQ_ERR_BIT    = 0;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bier_req_s;
endpackage

// *** src/bier_regs.sv ***
// bias enable, identification and error flag registers with interrupt
// assumes synchronous fault inputs and a master that never overlaps strobes
`timescale 1ns/100ps
module bier_regs
  import bier_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [1:0] SILICON_REVISION = 2'h0,
  parameter logic [1:0] MODEL_CODE       = 2'h0
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // register port
  input  wire bier_req_s   regReq,
  output logic [15:0]      regRdata,
  // analog side
  input  wire logic [11:0] faultDetect,
  output logic [15:0]      biasVoltageOutput,
  // interrupt
  output logic             irq
);
  logic [15:0] biasEn_r;
  logic [15:0] errFlags_r;
  logic [15:0] errEn_r;
  logic [1:0]  irqStat_r;
  logic [1:0]  irqMask_r;
  logic [15:0] rdMux;
  logic [15:0] errSet;
  logic [15:0] errClr;
  logic [7:0]  idValue;

  assign idValue = {ID_RSVD, SILICON_REVISION, MODEL_CODE};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      biasEn_r <= BIAS_EN_RESET;
    end else if (regReq.wr && regReq.addr == ADDR_BIAS_EN) begin
      biasEn_r <= regReq.wdata;
    end
  end

  assign biasVoltageOutput = biasEn_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      errEn_r <= ERR_EN_RESET;
    end else if (regReq.wr && regReq.addr == ADDR_ERR_EN) begin
      errEn_r <= regReq.wdata & ERR_IMPL_MASK;
    end
  end

  // gated set; bit eleven carries the positive input fault
  assign errSet = {4'h0, faultDetect} & errEn_r;
  assign errClr = (regReq.wr && regReq.addr == ADDR_ERR) ? regReq.wdata : 16'h0000;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      errFlags_r <= ERR_RESET;
    end else begin
      errFlags_r <= ((errFlags_r & ~errClr) | errSet) & ERR_IMPL_MASK;
    end
  end

  // sticky interrupt status, cleared by reading it; a new event wins over the read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_r <= IRQ_RESET;
    end else begin
      irqStat_r <= ((regReq.rd && regReq.addr == ADDR_IRQ_STAT) ? IRQ_RESET : irqStat_r)
                   | {1'b0, |errSet};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqMask_r <= IRQ_RESET;
    end else if (regReq.wr && regReq.addr == ADDR_IRQ_MASK) begin
      irqMask_r <= regReq.wdata[1:0];
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  // read-only identification; reserved bits read zero
  always_comb begin
    case (regReq.addr)
      ADDR_BIAS_EN:  rdMux = biasEn_r;
      ADDR_ID:       rdMux = {8'h00, idValue};
      ADDR_ERR:      rdMux = errFlags_r & ERR_IMPL_MASK;
      ADDR_ERR_EN:   rdMux = errEn_r;
      ADDR_IRQ_STAT: rdMux = {14'h0000, irqStat_r};
      ADDR_IRQ_MASK: rdMux = {14'h0000, irqMask_r};
      default:       rdMux = 16'h0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 16'h0000;
    end else if (regReq.rd) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= 16'h0000;
    end
  end
endmodule

// *** sim/bier_regs_monitor.sv ***
// port assertions for the bias, identification and error register slice
// assumes one clock domain and bind onto bier_regs
`timescale 1ns/100ps
module bier_regs_monitor
  import bier_pkg::*;
(
  // watched ports
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire bier_req_s   regReq,
  input wire logic [15:0] regRdata,
  input wire logic [11:0] faultDetect,
  input wire logic [15:0] biasVoltageOutput,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic wB = regReq.wr && regReq.addr == ADDR_BIAS_EN;
  wire logic rB = regReq.rd && regReq.addr == ADDR_BIAS_EN;
  wire logic rI = regReq.rd && regReq.addr == ADDR_ID;
  wire logic rE = regReq.rd && regReq.addr == ADDR_ERR;
  a_bias_write: assert property (wB |=> biasVoltageOutput == $past(regReq.wdata))
    else $error("bias write lost");
  a_bias_hold: assert property (!wB |=> $stable(biasVoltageOutput))
    else $error("bias changed unasked");
  a_bias_read: assert property (rB |=> regRdata == $past(biasVoltageOutput))
    else $error("bias readback wrong");
  // async reset must clear outputs with no edge needed
  a_reset_clear: assert property (disable iff (1'b0) !reset_n |-> !irq && !biasVoltageOutput)
    else $error("outputs not cleared in reset");
  a_id_byte: assert property (rI |=> regRdata[15:8] == 8'h00)
    else $error("id upper byte set");
  a_id_rsvd: assert property (rI |=> regRdata[7:4] == ID_RSVD)
    else $error("id reserved nibble set");
  a_err_rsvd: assert property (rE |=> regRdata[15:12] == 4'h0)
    else $error("error reserved bits set");
  a_read_idle: assert property (!regReq.rd |=> regRdata == 16'h0000)
    else $error("read data outside read");
endmodule
bind bier_regs bier_regs_monitor u_bier_regs_monitor (.sys_clk, .reset_n, .regReq, .regRdata,
  .faultDetect, .biasVoltageOutput, .irq);

// *** sim/bier_regs_tb_top.sv ***
// directed bench for the register slice
// assumes default identity parameters of zero
`timescale 1ns/100ps
`define CK(x, e) begin tests_run++; if ((x) !== (e)) begin fail_count++; \
  $display("mismatch %0t %h %h", $time, x, e); end end
module bier_regs_tb_top
  import bier_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b1;
  bier_req_s   regReq = '0;
  logic [11:0] faultDetect = 12'h000;
  logic [15:0] regRdata;
  logic [15:0] biasVoltageOutput;
  logic        irq;
  int          fail_count = 0;
  int          tests_run = 0;
  always #20 sys_clk = ~sys_clk;
  bier_regs u_bier_regs (.sys_clk, .reset_n, .regReq, .regRdata, .faultDetect,
    .biasVoltageOutput, .irq);
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge sys_clk) regReq <= {a, d, 2'b10};
    @(posedge sys_clk) regReq <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge sys_clk) regReq <= {a, 16'h0000, 2'b01};
    @(posedge sys_clk) regReq <= '0;
    #1 `CK(regRdata, e)
  endtask
  task automatic t_bias;
    rd(ADDR_ERR, 16'h0000);
    wr(ADDR_BIAS_EN, 16'hffff);
    #1 `CK(biasVoltageOutput, 16'hffff)
    wr(ADDR_BIAS_EN, 16'h8001);
    rd(ADDR_BIAS_EN, 16'h8001);
    wr(ADDR_ID, 16'hffff);
    rd(ADDR_ID, 16'h0000);
    rd(8'h0a, 16'h0000);
  endtask
  task automatic t_err;
    wr(ADDR_ERR_EN, 16'h0800);
    @(posedge sys_clk) faultDetect <= 12'hfff;
    wr(ADDR_IRQ_MASK, 16'h0001);
    rd(ADDR_ERR, 16'h0800);
    `CK(irq, 1'b1)
    wr(ADDR_ERR, 16'h0800);
    rd(ADDR_ERR, 16'h0800);
    @(posedge sys_clk) faultDetect <= 12'h000;
    wr(ADDR_ERR, 16'h0000);
    rd(ADDR_ERR, 16'h0800);
    wr(ADDR_ERR, 16'h0800);
    rd(ADDR_ERR, 16'h0000);
    rd(ADDR_IRQ_STAT, 16'h0001);
    `CK(irq, 1'b0)
  endtask
  task automatic results;
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a real falling edge at time zero, so the asynchronous reset clears every flop
  initial begin
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_bias;
    t_err;
    results;
  end
  // generous margin over the few dozen cycles of traffic
  initial begin
    #40000;
    fail_count++;
    results;
  end
endmodule
